// [include/eof_pkg.sv]
package eof_pkg;
  // Object dictionary indices.
  localparam logic [15:0] IDX_ERR_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_ERR_REACT = 16'h1029;
  localparam logic [15:0] IDX_DOUT = 16'h6200;
  localparam logic [15:0] IDX_DFB_SEL = 16'h6206;
  localparam logic [15:0] IDX_DFB_LVL = 16'h6207;
  localparam logic [15:0] IDX_PWM_DUTY = 16'h6500;
  localparam logic [15:0] IDX_PWM_PERIOD = 16'h6510;
  localparam logic [15:0] IDX_PFB_SEL = 16'h6543;
  localparam logic [15:0] IDX_PFB_DUTY = 16'h6544;

  // Subindices.
  localparam logic [7:0] SUB_VAR = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_OUT_ERR = 8'h02;
  localparam logic [7:0] SUB_IN_ERR = 8'h03;

  // Error reaction settings.
  localparam logic [7:0] REACT_PREOP = 8'h00;
  localparam logic [7:0] REACT_KEEP = 8'h01;
  localparam logic [7:0] REACT_STOP = 8'h02;
  localparam logic [7:0] REACT_RST = 8'h00;

  // Error codes and summary values.
  localparam logic [15:0] ERR_STACK = 16'h6102;
  localparam logic [7:0] ERRSUM_NONE = 8'h00;
  localparam logic [7:0] ERRSUM_GENERIC = 8'h01;

  // Output fallback and PWM values.
  localparam logic [7:0] FB_ON = 8'h01;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] DUTY_QUARTER = 16'h4000;
  localparam logic [15:0] PERIOD_RST = 16'h03e8;

  typedef enum logic [1:0] {
    NMT_PREOP,
    NMT_OPER,
    NMT_STOP
  } eof_nmt_t;
endpackage

// [src/eof_nmt.sv]
`timescale 1ns/10ps
// Node state tracker: picks the error reaction and raises the one-shot apply pulse.
module eof_nmt (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic err_evt_in,
  input wire logic err_stack_in,
  input wire logic [7:0] react_in,
  input wire logic start_in,
  output eof_pkg::eof_nmt_t state_out,
  output logic apply_out,
  output logic fault_out
);
  typedef struct packed {
    eof_pkg::eof_nmt_t state;
    logic apply;
    logic fault;
  } eof_nmt_st_t;

  eof_nmt_st_t r;
  eof_nmt_st_t n;

  always_comb begin
    n = r;
    n.apply = 1'b0;
    if (err_evt_in) begin
      if (err_stack_in) begin
        // A stack overrun is fatal; only reset clears the latch.
        n.fault = 1'b1;
        n.state = eof_pkg::NMT_STOP;
        n.apply = 1'b1;
      end else begin
        case (react_in)
          eof_pkg::REACT_PREOP: begin
            if (r.state != eof_pkg::NMT_PREOP) begin
              n.state = eof_pkg::NMT_PREOP;
              n.apply = 1'b1;
            end
          end
          eof_pkg::REACT_STOP: begin
            if (r.state != eof_pkg::NMT_STOP) begin
              n.state = eof_pkg::NMT_STOP;
              n.apply = 1'b1;
            end
          end
          default: begin
            n.state = r.state;
          end
        endcase
      end
    end else if (start_in && !r.fault) begin
      // A start restarts the node unless an error event comes in the same cycle or the stack fault is set.
      n.state = eof_pkg::NMT_OPER;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r.state <= eof_pkg::NMT_PREOP;
      r.apply <= 1'b0;
      r.fault <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign state_out = r.state;
  assign apply_out = r.apply;
  assign fault_out = r.fault;
endmodule

// [src/eof_top.sv]
`timescale 1ns/10ps
// Function
// - Setting 0 preop, 1 keep, 2 stopped.
// - One setting covers every error source except stack overrun.
// - Subentries 2 and 3 are refused.
// - Stack overrun forces outputs to fallback.
// - Stack overrun clears only by reset.
// - Fallback only when node state changes, or on every stack overrun.
// - Masked digital outputs take fallback level bits.
// - Unmasked outputs stay unchanged on error.
// - Selected PWM channels load fallback duty.
// - Fallback duty uses the normal scale.
// - Outputs hold until new data writes, or until reset after stack overrun, which locks data writes out.
// - Duty scales linearly over sixteen bits.
module eof_top #(
  parameter int DO_N = 8,
  parameter int PWM_N = 2
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic od_wr_in,
  input wire logic od_rd_in,
  input wire logic [15:0] od_index_in,
  input wire logic [7:0] od_sub_in,
  input wire logic [15:0] od_wdata_in,
  input wire logic err_evt_in,
  input wire logic [15:0] err_code_in,
  input wire logic start_in,
  output logic od_ack_out,
  output logic od_err_out,
  output logic [15:0] od_rdata_out,
  output logic [DO_N-1:0] dig_out_out,
  output logic [PWM_N-1:0][15:0] pwm_duty_out,
  output logic [PWM_N-1:0][15:0] pwm_period_out,
  output eof_pkg::eof_nmt_t nmt_state_out,
  output logic stack_fault_out
);
  if (DO_N < 1 || DO_N > 8) begin : g_bad_do
    $error("DO_N must be 1 to 8");
  end
  if (PWM_N < 1 || PWM_N > 254) begin : g_bad_pwm
    $error("PWM_N must be 1 to 254");
  end

  typedef struct packed {
    logic [7:0] react;
    logic [7:0] errsum;
    logic [DO_N-1:0] dout;
    logic [DO_N-1:0] dsel;
    logic [DO_N-1:0] dlvl;
    logic [PWM_N-1:0][15:0] duty;
    logic [PWM_N-1:0][15:0] period;
    logic [PWM_N-1:0][7:0] psel;
    logic [PWM_N-1:0][15:0] pfb;
    logic ack;
    logic nack;
    logic [15:0] rdata;
  } eof_state_t;

  eof_state_t r;
  eof_state_t n;
  logic err_stack;
  logic apply_w;
  logic [PWM_N-1:0] ch_hit;

  assign err_stack = (err_code_in == eof_pkg::ERR_STACK);

  eof_nmt u_nmt (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .err_evt_in(err_evt_in),
    .err_stack_in(err_stack),
    .react_in(r.react),
    .start_in(start_in),
    .state_out(nmt_state_out),
    .apply_out(apply_w),
    .fault_out(stack_fault_out)
  );

  for (genvar g = 0; g < PWM_N; g++) begin : g_ch
    assign ch_hit[g] = (od_sub_in == 8'(g + 1));
  end

  always_comb begin
    logic ok;
    logic dsub;
    logic [15:0] rd;
    n = r;
    ok = 1'b0;
    rd = 16'h0000;
    dsub = (od_sub_in == eof_pkg::SUB_FIRST);
    n.ack = 1'b0;
    n.nack = 1'b0;
    case (od_index_in)
      eof_pkg::IDX_ERR_SUMMARY: begin
        ok = (od_sub_in == eof_pkg::SUB_VAR) && !od_wr_in;
        rd = {8'h00, r.errsum};
      end
      eof_pkg::IDX_ERR_REACT: begin
        // Separate output and input error entries do not exist.
        ok = dsub && (!od_wr_in || od_wdata_in[7:0] <= eof_pkg::REACT_STOP);
        rd = {8'h00, r.react};
        if (od_wr_in && ok) begin
          n.react = od_wdata_in[7:0];
        end
      end
      eof_pkg::IDX_DOUT: begin
        // Data writes are locked out while the stack fault holds the fallback.
        ok = dsub && !(od_wr_in && stack_fault_out);
        rd = 16'(r.dout);
        if (od_wr_in && ok) begin
          n.dout = od_wdata_in[DO_N-1:0];
        end
      end
      eof_pkg::IDX_DFB_SEL: begin
        ok = dsub;
        rd = 16'(r.dsel);
        if (od_wr_in && ok) begin
          n.dsel = od_wdata_in[DO_N-1:0];
        end
      end
      eof_pkg::IDX_DFB_LVL: begin
        ok = dsub;
        rd = 16'(r.dlvl);
        if (od_wr_in && ok) begin
          n.dlvl = od_wdata_in[DO_N-1:0];
        end
      end
      eof_pkg::IDX_PWM_DUTY: begin
        ok = (|ch_hit) && !(od_wr_in && stack_fault_out);
        for (int i = 0; i < PWM_N; i++) begin
          if (ch_hit[i]) begin
            rd = r.duty[i];
            if (od_wr_in && ok) begin
              n.duty[i] = od_wdata_in;
            end
          end
        end
      end
      eof_pkg::IDX_PWM_PERIOD: begin
        ok = |ch_hit;
        for (int i = 0; i < PWM_N; i++) begin
          if (ch_hit[i]) begin
            rd = r.period[i];
            if (od_wr_in) begin
              n.period[i] = od_wdata_in;
            end
          end
        end
      end
      eof_pkg::IDX_PFB_SEL: begin
        ok = |ch_hit;
        for (int i = 0; i < PWM_N; i++) begin
          if (ch_hit[i]) begin
            rd = {8'h00, r.psel[i]};
            if (od_wr_in) begin
              n.psel[i] = od_wdata_in[7:0];
            end
          end
        end
      end
      eof_pkg::IDX_PFB_DUTY: begin
        ok = |ch_hit;
        for (int i = 0; i < PWM_N; i++) begin
          if (ch_hit[i]) begin
            rd = r.pfb[i];
            if (od_wr_in) begin
              n.pfb[i] = od_wdata_in;
            end
          end
        end
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    if (od_wr_in || od_rd_in) begin
      n.ack = ok;
      n.nack = !ok;
      if (od_rd_in && ok) begin
        n.rdata = rd;
      end
    end
    if (start_in && !stack_fault_out) begin
      n.errsum = eof_pkg::ERRSUM_NONE;
    end
    // A new error in the same cycle as the restart keeps the summary set.
    if (err_evt_in) begin
      n.errsum = eof_pkg::ERRSUM_GENERIC;
    end
    // The apply pulse is a single cycle, so later data writes win again.
    if (apply_w) begin
      for (int i = 0; i < DO_N; i++) begin
        if (r.dsel[i]) begin
          n.dout[i] = r.dlvl[i];
        end
      end
      for (int i = 0; i < PWM_N; i++) begin
        if (r.psel[i] == eof_pkg::FB_ON) begin
          // Fallback duty is stored raw, on the same linear 16-bit scale.
          n.duty[i] = r.pfb[i];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.react <= eof_pkg::REACT_RST;
      r.errsum <= eof_pkg::ERRSUM_NONE;
      r.duty <= {PWM_N{eof_pkg::DUTY_RST}};
      r.period <= {PWM_N{eof_pkg::PERIOD_RST}};
    end else begin
      r <= n;
    end
  end

  assign od_ack_out = r.ack;
  assign od_err_out = r.nack;
  assign od_rdata_out = r.rdata;
  assign dig_out_out = r.dout;
  // Duty 0 is 0% and all ones is 100%, passed unchanged to the generator.
  assign pwm_duty_out = r.duty;
  assign pwm_period_out = r.period;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic plain_err;
  logic dout_wr;
  assign plain_err = err_evt_in && !err_stack;
  assign dout_wr = od_wr_in && od_index_in == eof_pkg::IDX_DOUT;

  property p_react_preop;
    plain_err && r.react == eof_pkg::REACT_PREOP |=> nmt_state_out == eof_pkg::NMT_PREOP;
  endproperty
  a_react_preop: assert property (p_react_preop) else $error("preop reaction missed");

  property p_react_stop;
    plain_err && r.react == eof_pkg::REACT_STOP |=> nmt_state_out == eof_pkg::NMT_STOP;
  endproperty
  a_react_stop: assert property (p_react_stop) else $error("stop reaction missed");

  property p_react_keep;
    plain_err && r.react == eof_pkg::REACT_KEEP |=> $stable(nmt_state_out) && !apply_w;
  endproperty
  a_react_keep: assert property (p_react_keep) else $error("keep reaction changed state");

  property p_stack_fault;
    err_evt_in && err_stack |=> stack_fault_out && apply_w ##1 nmt_state_out == eof_pkg::NMT_STOP;
  endproperty
  a_stack_fault: assert property (p_stack_fault) else $error("stack overrun not handled");

  property p_fault_sticky;
    stack_fault_out |=> stack_fault_out;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("stack fault cleared");

  property p_dig_fallback;
    apply_w |=> (dig_out_out & $past(r.dsel)) == ($past(r.dlvl) & $past(r.dsel));
  endproperty
  a_dig_fallback: assert property (p_dig_fallback) else $error("digital fallback wrong");

  property p_dig_keep;
    apply_w && !dout_wr |=> (dig_out_out & ~$past(r.dsel)) == ($past(dig_out_out) & ~$past(r.dsel));
  endproperty
  a_dig_keep: assert property (p_dig_keep) else $error("unmasked output changed");

  property p_pwm_fallback;
    apply_w && r.psel[0] == eof_pkg::FB_ON |=> pwm_duty_out[0] == $past(r.pfb[0]);
  endproperty
  a_pwm_fallback: assert property (p_pwm_fallback) else $error("pwm fallback wrong");

  property p_hold;
    !apply_w && !dout_wr |=> $stable(dig_out_out);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without write");

  property p_sub_refused;
    od_wr_in && od_index_in == eof_pkg::IDX_ERR_REACT &&
      (od_sub_in == eof_pkg::SUB_OUT_ERR || od_sub_in == eof_pkg::SUB_IN_ERR) |=> od_err_out && !od_ack_out;
  endproperty
  a_sub_refused: assert property (p_sub_refused) else $error("subentry 2 or 3 accepted");

  property p_fault_lock;
    od_wr_in && od_index_in == eof_pkg::IDX_DOUT && stack_fault_out |=> od_err_out && !od_ack_out;
  endproperty
  a_fault_lock: assert property (p_fault_lock) else $error("data write taken during stack fault");

  property p_errsum_set;
    err_evt_in |=> r.errsum == eof_pkg::ERRSUM_GENERIC;
  endproperty
  a_errsum_set: assert property (p_errsum_set) else $error("error summary not set");

  // Restart is only checked without a fault, since the fault must survive every command.
  property p_restart;
    start_in && !err_evt_in && !stack_fault_out |=> nmt_state_out == eof_pkg::NMT_OPER;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reach operational");

  c_quarter: cover property (apply_w && r.psel[0] == eof_pkg::FB_ON &&
    r.pfb[0] == eof_pkg::DUTY_QUARTER ##1 pwm_duty_out[0] == eof_pkg::DUTY_QUARTER);
  c_restart: cover property (nmt_state_out == eof_pkg::NMT_STOP ##1 nmt_state_out == eof_pkg::NMT_OPER);
  c_stack: cover property (err_evt_in && err_stack ##1 stack_fault_out);
  c_keep: cover property (plain_err && r.react == eof_pkg::REACT_KEEP);
endmodule

// [sim/eof_master.sv]
`timescale 1ns/10ps
// Network master and configuration tool: object accesses, error events and node start.
module eof_master (
  input wire logic clk_in,
  input wire logic od_ack_in,
  input wire logic od_err_in,
  input wire logic [15:0] od_rdata_in,
  output logic od_wr_out,
  output logic od_rd_out,
  output logic [15:0] od_index_out,
  output logic [7:0] od_sub_out,
  output logic [15:0] od_wdata_out,
  output logic err_evt_out,
  output logic [15:0] err_code_out,
  output logic start_out
);
  initial begin
    od_wr_out = 1'b0;
    od_rd_out = 1'b0;
    od_index_out = 16'h0000;
    od_sub_out = 8'h00;
    od_wdata_out = 16'h0000;
    err_evt_out = 1'b0;
    err_code_out = 16'h0000;
    start_out = 1'b0;
  end

  // Index, subindex and data are inverted after release so a stale value can never pass for a live one.
  task automatic access(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
                        output logic a, output logic e, output logic [15:0] r);
    @(posedge clk_in);
    #1;
    od_wr_out = wr;
    od_rd_out = ~wr;
    od_index_out = i;
    od_sub_out = s;
    od_wdata_out = d;
    @(posedge clk_in);
    #1;
    a = od_ack_in;
    e = od_err_in;
    r = od_rdata_in;
    od_wr_out = 1'b0;
    od_rd_out = 1'b0;
    od_index_out = ~i;
    od_sub_out = ~s;
    od_wdata_out = ~d;
  endtask

  task automatic pulse_err(input logic [15:0] c);
    @(posedge clk_in);
    #1;
    err_evt_out = 1'b1;
    err_code_out = c;
    @(posedge clk_in);
    #1;
    err_evt_out = 1'b0;
    err_code_out = ~c;
  endtask

  // The start command is a one-cycle pulse, sent with no check that the error cause has gone away.
  task automatic pulse_start;
    @(posedge clk_in);
    #1;
    start_out = 1'b1;
    @(posedge clk_in);
    #1;
    start_out = 1'b0;
  endtask
endmodule

// [sim/test_eof_top.sv]
`timescale 1ns/10ps
module test_eof_top;
  typedef struct packed {
    logic wr;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [15:0] wd;
    logic xe;
    logic [15:0] xr;
  } eof_row_t;
  logic clk_in;
  logic nrst_in;
  logic od_wr, od_rd, ack, err, evt, start, fault, a, e;
  logic [15:0] idx, wd, rd, code, r;
  logic [7:0] sub, dig;
  logic [1:0][15:0] duty, period;
  eof_pkg::eof_nmt_t st;
  int errors = 0;
  int n_tests = 0;
  eof_row_t rows [20];

  eof_top eof_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .od_wr_in(od_wr), .od_rd_in(od_rd),
    .od_index_in(idx), .od_sub_in(sub), .od_wdata_in(wd), .err_evt_in(evt), .err_code_in(code),
    .start_in(start), .od_ack_out(ack), .od_err_out(err), .od_rdata_out(rd), .dig_out_out(dig),
    .pwm_duty_out(duty), .pwm_period_out(period), .nmt_state_out(st), .stack_fault_out(fault));
  eof_master eof_master_i (.clk_in(clk_in), .od_ack_in(ack), .od_err_in(err), .od_rdata_in(rd),
    .od_wr_out(od_wr), .od_rd_out(od_rd), .od_index_out(idx), .od_sub_out(sub), .od_wdata_out(wd),
    .err_evt_out(evt), .err_code_out(code), .start_out(start));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
                     input logic xe, input logic [15:0] xr);
    eof_master_i.access(w, i, s, d, a, e, r);
    chk({14'h0, a, e}, xe ? 16'h0001 : 16'h0002, "answer");
    if (!w && !xe) begin
      chk(r, xr, "read data");
    end
  endtask

  task automatic cyc;
    @(posedge clk_in);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #50000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    rows = '{'{1, 16'h6206, 8'h01, 16'h0003, 0, 16'h0}, '{1, 16'h6207, 8'h01, 16'h0001, 0, 16'h0},
             '{1, 16'h6200, 8'h01, 16'h000c, 0, 16'h0}, '{0, 16'h6206, 8'h01, 16'h0, 0, 16'h0003},
             '{0, 16'h1029, 8'h01, 16'h0, 0, 16'h0000}, '{1, 16'h1029, 8'h02, 16'h0, 1, 16'h0},
             '{1, 16'h1029, 8'h03, 16'h0, 1, 16'h0}, '{1, 16'h1029, 8'h01, 16'h0003, 1, 16'h0},
             '{1, 16'h1001, 8'h00, 16'h0, 1, 16'h0}, '{0, 16'h1001, 8'h00, 16'h0, 0, 16'h0000},
             '{0, 16'h6510, 8'h01, 16'h0, 0, 16'h03e8}, '{0, 16'h6500, 8'h01, 16'h0, 0, 16'h0000},
             '{1, 16'h6543, 8'h01, 16'h0001, 0, 16'h0}, '{1, 16'h6544, 8'h01, 16'h4000, 0, 16'h0},
             '{1, 16'h6500, 8'h02, 16'hffff, 0, 16'h0}, '{1, 16'h6500, 8'h03, 16'h0, 1, 16'h0},
             '{0, 16'h1234, 8'h00, 16'h0, 1, 16'h0}, '{1, 16'h6510, 8'h02, 16'h0021, 0, 16'h0},
             '{0, 16'h6207, 8'h01, 16'h0, 0, 16'h0001}, '{0, 16'h6544, 8'h01, 16'h0, 0, 16'h4000}};
    nrst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    foreach (rows[k]) begin
      obj(rows[k].wr, rows[k].idx, rows[k].sub, rows[k].wd, rows[k].xe, rows[k].xr);
    end
    chk(duty[1], 16'hffff, "full duty");
    chk(period[1], 16'h0021, "period write");
    $display("test table done");
    eof_master_i.pulse_err(16'h8130);
    cyc();
    chk(16'(st), 16'(eof_pkg::NMT_PREOP), "no change state");
    chk({8'h0, dig}, 16'h000c, "no change outputs");
    eof_master_i.pulse_start();
    chk(16'(st), 16'(eof_pkg::NMT_OPER), "start");
    obj(1'b0, 16'h1001, 8'h00, 16'h0, 1'b0, 16'h0000);
    obj(1'b1, 16'h1029, 8'h01, 16'h0001, 1'b0, 16'h0);
    eof_master_i.pulse_err(16'h8110);
    cyc();
    chk(16'(st), 16'(eof_pkg::NMT_OPER), "keep state");
    chk({8'h0, dig}, 16'h000c, "keep outputs");
    obj(1'b0, 16'h1001, 8'h00, 16'h0, 1'b0, 16'h0001);
    $display("test keep done");
    obj(1'b1, 16'h1029, 8'h01, 16'h0000, 1'b0, 16'h0);
    eof_master_i.pulse_err(16'h8140);
    chk(16'(st), 16'(eof_pkg::NMT_PREOP), "to preop");
    cyc();
    chk({8'h0, dig}, 16'h000d, "digital fallback");
    chk(duty[0], 16'h4000, "pwm fallback");
    chk(duty[1], 16'hffff, "pwm unselected");
    obj(1'b1, 16'h6200, 8'h01, 16'h00f0, 1'b0, 16'h0);
    chk({8'h0, dig}, 16'h00f0, "new data after error");
    $display("test preop done");
    eof_master_i.pulse_start();
    obj(1'b1, 16'h1029, 8'h01, 16'h0002, 1'b0, 16'h0);
    eof_master_i.pulse_err(16'h8120);
    chk(16'(st), 16'(eof_pkg::NMT_STOP), "to stopped");
    cyc();
    chk({8'h0, dig}, 16'h00f1, "stopped fallback");
    obj(1'b1, 16'h6200, 8'h01, 16'h0000, 1'b0, 16'h0);
    eof_master_i.pulse_err(16'h1000);
    cyc();
    chk({8'h0, dig}, 16'h0000, "repeat error");
    fork
      eof_master_i.pulse_err(16'h8130);
      eof_master_i.pulse_start();
    join
    chk(16'(st), 16'(eof_pkg::NMT_STOP), "error beats start");
    obj(1'b0, 16'h1001, 8'h00, 16'h0, 1'b0, 16'h0001);
    $display("test stop done");
    eof_master_i.pulse_start();
    obj(1'b1, 16'h1029, 8'h01, 16'h0001, 1'b0, 16'h0);
    eof_master_i.pulse_err(16'h6102);
    chk({fault, 13'h0, st}, {1'b1, 13'h0, eof_pkg::NMT_STOP}, "stack overrun");
    cyc();
    chk({8'h0, dig}, 16'h0001, "stack fallback");
    obj(1'b1, 16'h6200, 8'h01, 16'h00ff, 1'b1, 16'h0);
    eof_master_i.pulse_start();
    cyc();
    chk({fault, 13'h0, st}, {1'b1, 13'h0, eof_pkg::NMT_STOP}, "start in fault");
    nrst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk({fault, 13'h0, st}, 16'(eof_pkg::NMT_PREOP), "reset state");
    chk({8'h0, dig}, 16'h0000, "reset outputs");
    chk(duty[0] | duty[1], 16'h0000, "reset duty");
    chk(period[0] & period[1], 16'h03e8, "reset period");
    nrst_in = 1'b1;
    obj(1'b0, 16'h1029, 8'h01, 16'h0, 1'b0, 16'h0000);
    $display("test stack done");
    stop_test();
  end
endmodule
